// file: timer_mode_pkg.sv
// Purpose: Shared constants for the timer mode and control register block
// Assumes: APB slave with 32-bit data, one byte-wide register per word
// Notes:   Offsets are byte addresses within the block
package timer_mode_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] MODE_OFFSET = 8'h00;
  localparam logic [7:0] CTRL_OFFSET = 8'h04;

  // ****************************************
  // Mode register fields
  // ****************************************
  localparam int MODE_RUN_BIT   = 7;
  localparam int MODE_BUFB_BIT  = 5;
  localparam int MODE_BUFA_BIT  = 4;
  localparam int MODE_PULSE_MODE_CH_D_BIT  = 2;
  localparam int MODE_PULSE_MODE_CH_C_BIT  = 1;
  localparam int MODE_PULSE_MODE_CH_B_BIT  = 0;
  localparam logic [7:0] MODE_RSVD_MASK = 8'h48;
  localparam logic [7:0] MODE_WR_MASK   = 8'hB7;
  localparam logic [7:0] MODE_RESET     = 8'h00;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTRL_CLR_BIT   = 7;
  localparam int CTRL_CKS_LSB   = 4;
  localparam int CTRL_LVL_LSB   = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ****************************************
  // Clock select codes
  // ****************************************
  localparam logic [2:0] CKS_DIV1 = 3'h0;
  localparam logic [2:0] CKS_DIV2 = 3'h1;
  localparam logic [2:0] CKS_DIV4 = 3'h2;
  localparam logic [2:0] CKS_DIV8 = 3'h3;
  localparam int         CKS_EXT_BIT = 2;

  // ****************************************
  // Prescaler
  // ****************************************
  localparam int PRESCALE_W = 3;

endpackage

// file: count_tick_gen.sv
// Purpose: Count enable generator for the timer counter
// Assumes: External event input synchronous to clk
// Notes:   Divided ticks are one-cycle enables, never derived clocks
`timescale 1ns/100ps
`default_nettype none
module count_tick_gen
  import timer_mode_pkg::*;
#(
  parameter int DIV_W = PRESCALE_W
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [2:0] clock_select,
  input  wire logic       subclock_mode,
  input  wire logic       subclock_tick,
  input  wire logic       external_event_clock,
  output logic            count_tick
);

  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic             ext_prev_r;
  logic             ext_prev_nxt;
  logic             tick_sel;

  // Free prescaler; it keeps running so phase is independent of run
  always_comb begin
    div_nxt      = div_r + {{(DIV_W-1){1'b0}}, 1'b1};
    ext_prev_nxt = external_event_clock;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r      <= '0;
      ext_prev_r <= 1'b0;
    end else begin
      div_r      <= div_nxt;
      ext_prev_r <= ext_prev_nxt;
    end
  end

  // Source select; switching codes may shorten one period
  always_comb begin
    tick_sel = 1'b0;
    if (clock_select[CKS_EXT_BIT]) begin
      tick_sel = external_event_clock & ~ext_prev_r;
    end else begin
      unique case (clock_select[1:0])
        CKS_DIV1[1:0]: tick_sel = subclock_mode ? subclock_tick : 1'b1;
        CKS_DIV2[1:0]: tick_sel = (div_r[0] == 1'b1);
        CKS_DIV4[1:0]: tick_sel = (div_r[1:0] == 2'b11);
        CKS_DIV8[1:0]: tick_sel = (div_r[2:0] == 3'b111);
      endcase
    end
  end

  // Halted counter sees no tick at all
  assign count_tick = run & tick_sel;

endmodule
`default_nettype wire

// file: timer_mode_ctrl.sv
// Purpose: Mode and control registers of a 16-bit timer over APB
// Assumes: Zero-wait APB slave, all inputs synchronous to clk
// Notes:   Outputs steer the counter, the channels and the pin levels
//
// Summary of operation
// [RQ1] Counter runs only while run bit set
// [RQ2] Mode bits 6 and 3 read one
// [RQ3] Bit 5 pairs register D behind B
// [RQ4] Bit 4 pairs register C behind A
// [RQ5] Bit 2 selects pulse mode on D
// [RQ6] Bit 1 selects pulse mode on C
// [RQ7] Bit 0 selects pulse mode on B
// [RQ8] Clear counter on match A when enabled
// [RQ9] Otherwise counter runs free, never cleared
// [RQ10] Codes 0 to 3 divide clock 1,2,4,8
// [RQ11] Top code bit counts external rising edges
// [RQ12] Undivided code uses subclock in sub modes
// [RQ13] Bit 3 sets pin D before match
// [RQ14] Bit 2 sets pin C before match
// [RQ15] Bit 1 sets pin B before match
// [RQ16] Bit 0 sets pin A before match
// [RQ17] Level changes appear on pins at once
// [RQ18] Reset clears all writable bits
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module timer_mode_ctrl
  import timer_mode_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              subclock_mode,
  input  wire logic              subclock_tick,
  input  wire logic              external_event_clock,
  input  wire logic              compare_match_a,
  input  wire logic              compare_match_b,
  input  wire logic              compare_match_c,
  input  wire logic              compare_match_d,
  input  wire logic              channel_level_a,
  input  wire logic              channel_level_b,
  input  wire logic              channel_level_c,
  input  wire logic              channel_level_d,
  output logic                   counter_run,
  output logic                   count_tick,
  output logic                   counter_clear,
  output logic                   clear_on_match_a,
  output logic                   buffer_pair_a_enable,
  output logic                   buffer_pair_b_enable,
  output logic                   pulse_mode_ch_b,
  output logic                   pulse_mode_ch_c,
  output logic                   pulse_mode_ch_d,
  output logic                   timer_pin_a,
  output logic                   timer_pin_b,
  output logic                   timer_pin_c,
  output logic                   timer_pin_d
);

  // ****************************************
  // Bus decode
  // ****************************************
  logic       sel_mode;
  logic       sel_ctrl;
  logic       mapped;
  logic       setup_ph;
  logic       access_ph;
  logic       wr_mode;
  logic       wr_ctrl;
  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [3:0] seen_r;
  logic [3:0] seen_nxt;
  logic [3:0] match_v;
  logic [3:0] level_v;
  logic [3:0] pin_v;
  logic [2:0] clock_select;
  logic       first_r;

  // The whole address decodes; bits above the low byte must be zero
  assign sel_mode  = ({{(32-ADDR_W){1'b0}}, paddr} == {24'h0000_00, MODE_OFFSET});
  assign sel_ctrl  = ({{(32-ADDR_W){1'b0}}, paddr} == {24'h0000_00, CTRL_OFFSET});
  assign mapped    = sel_mode | sel_ctrl;
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_mode   = access_ph & pwrite & sel_mode;
  assign wr_ctrl   = access_ph & pwrite & sel_ctrl;

  // Zero wait states; unmapped access errors and writes nothing
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~mapped;
  assign prdata  = rdata_r;

  // ****************************************
  // Register file
  // ****************************************
  // Reserved mode bits are never stored, only forced on read
  always_comb begin
    mode_nxt = mode_r;
    ctrl_nxt = ctrl_r;
    if (wr_mode) begin
      // [RQ2] writes to reserved ignored
      mode_nxt = pwdata[7:0] & MODE_WR_MASK;
    end
    if (wr_ctrl) begin
      ctrl_nxt = pwdata[7:0];
    end
  end

  // Read data latched in setup so it is a flop in the access cycle
  always_comb begin
    rdata_nxt = rdata_r;
    if (setup_ph && !pwrite) begin
      rdata_nxt = 32'h0000_0000;
      if (sel_mode) begin
        // [RQ2] reserved bits read one
        rdata_nxt = {24'h0000_00, mode_r | MODE_RSVD_MASK};
      end else if (sel_ctrl) begin
        rdata_nxt = {24'h0000_00, ctrl_r};
      end
    end
  end

  // [RQ18] reset clears registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r  <= MODE_RESET;
      ctrl_r  <= CTRL_RESET;
      rdata_r <= 32'h0000_0000;
    end else begin
      mode_r  <= mode_nxt;
      ctrl_r  <= ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // Mode outputs
  // ****************************************
  // [RQ1] run gates counting
  assign counter_run          = mode_r[MODE_RUN_BIT];
  // [RQ3] pair D behind B
  assign buffer_pair_b_enable = mode_r[MODE_BUFB_BIT];
  // [RQ4] pair C behind A
  assign buffer_pair_a_enable = mode_r[MODE_BUFA_BIT];
  // [RQ5] pulse mode D
  assign pulse_mode_ch_d      = mode_r[MODE_PULSE_MODE_CH_D_BIT];
  // [RQ6] pulse mode C
  assign pulse_mode_ch_c      = mode_r[MODE_PULSE_MODE_CH_C_BIT];
  // [RQ7] pulse mode B
  assign pulse_mode_ch_b      = mode_r[MODE_PULSE_MODE_CH_B_BIT];
  assign clear_on_match_a     = ctrl_r[CTRL_CLR_BIT];
  assign clock_select         = ctrl_r[CTRL_CKS_LSB +: 3];

  // [RQ8] clear on match A
  // [RQ9] free run when disabled
  assign counter_clear = clear_on_match_a & compare_match_a;

  // ****************************************
  // Count enable
  // ****************************************
  // [RQ10] internal divide select
  // [RQ11] external edge count
  // [RQ12] subclock substitution
  count_tick_gen #(
    .DIV_W(PRESCALE_W)
  ) u_tick (
    .clk                  (clk),
    .rst                  (rst),
    .run                  (counter_run),
    .clock_select         (clock_select),
    .subclock_mode        (subclock_mode),
    .subclock_tick        (subclock_tick),
    .external_event_clock (external_event_clock),
    .count_tick           (count_tick)
  );

  // ****************************************
  // Pin initial levels
  // ****************************************
  assign match_v = {compare_match_d, compare_match_c, compare_match_b, compare_match_a};
  assign level_v = {channel_level_d, channel_level_c, channel_level_b, channel_level_a};

  // Match seen per channel; a match in the write cycle wins
  always_comb begin
    seen_nxt = seen_r;
    if (wr_ctrl) begin
      seen_nxt = 4'h0;
    end
    seen_nxt = seen_nxt | match_v;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_r  <= 4'h0;
      first_r <= 1'b1;
    end else begin
      seen_r  <= seen_nxt;
      first_r <= 1'b0;
    end
  end

  // [RQ13] [RQ14] [RQ15] [RQ16] level until first match
  // [RQ17] register drives pin directly
  assign pin_v = (seen_r & level_v) | (~seen_r & ctrl_r[CTRL_LVL_LSB +: 4]);
  assign timer_pin_a = pin_v[0];
  assign timer_pin_b = pin_v[1];
  assign timer_pin_c = pin_v[2];
  assign timer_pin_d = pin_v[3];

  // ****************************************
  // Assertions
  // ****************************************
  AST_HALT: assert property (@(posedge clk) disable iff (rst) // [RQ1]
    !counter_run |-> !count_tick) else $error("tick while halted");
  AST_RSVD: assert property (@(posedge clk) disable iff (rst) // [RQ2]
    setup_ph && !pwrite && sel_mode |=> prdata[6] && prdata[3])
    else $error("reserved mode bits not one");
  AST_BUFB: assert property (@(posedge clk) disable iff (rst) // [RQ3]
    wr_mode |=> buffer_pair_b_enable == $past(pwdata[5])) else $error("pair B wrong");
  AST_BUFA: assert property (@(posedge clk) disable iff (rst) // [RQ4]
    wr_mode |=> buffer_pair_a_enable == $past(pwdata[4])) else $error("pair A wrong");
  AST_PULSE_MODE_CH_D: assert property (@(posedge clk) disable iff (rst) // [RQ5]
    wr_mode |=> pulse_mode_ch_d == $past(pwdata[2])) else $error("pulse D wrong");
  AST_PULSE_MODE_CH_C: assert property (@(posedge clk) disable iff (rst) // [RQ6]
    wr_mode |=> pulse_mode_ch_c == $past(pwdata[1])) else $error("pulse C wrong");
  AST_PULSE_MODE_CH_B: assert property (@(posedge clk) disable iff (rst) // [RQ7]
    wr_mode |=> pulse_mode_ch_b == $past(pwdata[0])) else $error("pulse B wrong");
  AST_CLR_ON: assert property (@(posedge clk) disable iff (rst) // [RQ8]
    clear_on_match_a && compare_match_a |-> counter_clear) else $error("clear missed");
  AST_CLR_OFF: assert property (@(posedge clk) disable iff (rst) // [RQ9]
    !clear_on_match_a |-> !counter_clear) else $error("clear while free run");
  AST_DIV8: assert property (@(posedge clk) disable iff (rst) // [RQ10]
    count_tick && clock_select == CKS_DIV8 |=>
      (!count_tick || clock_select != CKS_DIV8)[*7]) else $error("divide by 8 wrong");
  AST_EXT: assert property (@(posedge clk) disable iff (rst) // [RQ11]
    counter_run && clock_select[2] && external_event_clock && !$past(external_event_clock)
      |-> count_tick) else $error("external edge missed");
  AST_SUB: assert property (@(posedge clk) disable iff (rst) // [RQ12]
    counter_run && clock_select == CKS_DIV1 && subclock_mode |-> count_tick == subclock_tick)
    else $error("subclock not used");
  AST_LVL_D: assert property (@(posedge clk) disable iff (rst) // [RQ13]
    !seen_r[3] |-> timer_pin_d == ctrl_r[3]) else $error("pin D level wrong");
  AST_LVL_C: assert property (@(posedge clk) disable iff (rst) // [RQ14]
    !seen_r[2] |-> timer_pin_c == ctrl_r[2]) else $error("pin C level wrong");
  AST_LVL_B: assert property (@(posedge clk) disable iff (rst) // [RQ15]
    !seen_r[1] |-> timer_pin_b == ctrl_r[1]) else $error("pin B level wrong");
  AST_LVL_A: assert property (@(posedge clk) disable iff (rst) // [RQ16]
    !seen_r[0] |-> timer_pin_a == ctrl_r[0]) else $error("pin A level wrong");
  AST_AT_ONCE: assert property (@(posedge clk) disable iff (rst) // [RQ17]
    wr_ctrl && match_v == 4'h0 |=> pin_v == $past(pwdata[3:0]))
    else $error("level write not on pins");
  AST_RESET: assert property (@(posedge clk) disable iff (rst) // [RQ18]
    first_r |-> mode_r == 8'h00 && ctrl_r == 8'h00 && !count_tick)
    else $error("registers not cleared by reset");

  // ****************************************
  // Write path and prescaler phase checks
  // ****************************************
  // Field-by-field landing of writes, and tick spacing for divide codes 1, 2 and 4
  AST_RUN_WR: assert property (@(posedge clk) disable iff (rst) // [RQ1]
    wr_mode |=> counter_run == $past(pwdata[7]))
    else $error("run bit not taken from write");
  AST_MODE_HOLD: assert property (@(posedge clk) disable iff (rst) // [RQ1]
    !wr_mode |=> mode_r == $past(mode_r))
    else $error("mode changed without write");
  AST_RSVD_WR: assert property (@(posedge clk) disable iff (rst) // [RQ2]
    wr_mode |=> (mode_r & MODE_RSVD_MASK) == 8'h00)
    else $error("reserved mode bits stored");
  AST_CLR_WR: assert property (@(posedge clk) disable iff (rst) // [RQ8]
    wr_ctrl |=> clear_on_match_a == $past(pwdata[7]))
    else $error("clear enable not taken from write");
  AST_CKS_WR: assert property (@(posedge clk) disable iff (rst) // [RQ10]
    wr_ctrl |=> clock_select == $past(pwdata[6:4]))
    else $error("clock select not taken from write");
  AST_DIV1: assert property (@(posedge clk) disable iff (rst) // [RQ10]
    counter_run && clock_select == CKS_DIV1 && !subclock_mode |-> count_tick)
    else $error("undivided tick missing");
  AST_DIV2: assert property (@(posedge clk) disable iff (rst) // [RQ10]
    count_tick && clock_select == CKS_DIV2 |=> !count_tick || clock_select != CKS_DIV2)
    else $error("divide by 2 wrong");
  AST_DIV4: assert property (@(posedge clk) disable iff (rst) // [RQ10]
    count_tick && clock_select == CKS_DIV4 |=>
      (!count_tick || clock_select != CKS_DIV4)[*3]) else $error("divide by 4 wrong");
  AST_EXT_ONLY: assert property (@(posedge clk) disable iff (rst) // [RQ11]
    clock_select[CKS_EXT_BIT] && !(external_event_clock && !$past(external_event_clock))
      |-> !count_tick) else $error("tick without external edge");
  AST_SEEN_SET: assert property (@(posedge clk) disable iff (rst) // [RQ13]
    match_v != 4'h0 |=> (seen_r & $past(match_v)) == $past(match_v))
    else $error("match not remembered");
  AST_CHAN_PIN: assert property (@(posedge clk) disable iff (rst) // [RQ16]
    seen_r != 4'h0 |-> ((pin_v ^ level_v) & seen_r) == 4'h0)
    else $error("pin not following channel after match");
  AST_LVL_WR: assert property (@(posedge clk) disable iff (rst) // [RQ17]
    wr_ctrl |=> ctrl_r[CTRL_LVL_LSB +: 4] == $past(pwdata[3:0]))
    else $error("level bits not taken from write");

endmodule
`default_nettype wire

// file: timer_mode_ctrl_tb_top.sv
// Purpose: Self-checking bench for the timer mode and control registers
// Assumes: Zero-wait APB slave, mode at 0x00, control at 0x04
// Notes:   Random register traffic with fixed seed plus hand-made corners
`timescale 1ns/100ps
`default_nettype none
module timer_mode_ctrl_tb_top
  import timer_mode_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst, psel, penable, pwrite, pslverr, pready;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        sub_mode, sub_tick, ext_clk, run, tick, clr, clr_en;
  logic [3:0]  cm, lvl, pin;
  logic        buf_a, buf_b, pwm_b, pwm_c, pwm_d, err;
  logic [2:0]  ph = 3'h0;
  int          err_total, n_tests, n;

  timer_mode_ctrl dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .subclock_mode(sub_mode), .subclock_tick(sub_tick),
    .external_event_clock(ext_clk), .compare_match_a(cm[0]), .compare_match_b(cm[1]),
    .compare_match_c(cm[2]), .compare_match_d(cm[3]), .channel_level_a(lvl[0]),
    .channel_level_b(lvl[1]), .channel_level_c(lvl[2]), .channel_level_d(lvl[3]),
    .counter_run(run), .count_tick(tick), .counter_clear(clr), .clear_on_match_a(clr_en),
    .buffer_pair_a_enable(buf_a), .buffer_pair_b_enable(buf_b),
    .pulse_mode_ch_b(pwm_b), .pulse_mode_ch_c(pwm_c), .pulse_mode_ch_d(pwm_d),
    .timer_pin_a(pin[0]), .timer_pin_b(pin[1]), .timer_pin_c(pin[2]), .timer_pin_d(pin[3]));

  // ****************************************
  // Clock and event sources
  // ****************************************
  // 8 ns clock
  always #4 clk = ~clk;
  // Free phase: external edge every 4 cycles, subclock tick every 8
  always @(posedge clk) ph <= ph + 3'h1;
  assign ext_clk  = ph[1];
  assign sub_tick = (ph == 3'h5);

  // ****************************************
  // Helpers
  // ****************************************
  // Four-state compare; an unknown bit matches only an unknown bit
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // APB transfer; holds request until pready sampled high or 16 cycles pass
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    err = pslverr;
    if (k >= 16) chk("pready", 32'h0000_0001, 32'h0000_0000);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask

  // Mode readback from written value
  function automatic logic [31:0] mode_exp(input logic [31:0] w);
    return {24'h00_0000, (w[7:0] & MODE_WR_MASK) | MODE_RSVD_MASK};
  endfunction

  // Count ticks over 64 consecutive edges, after settling
  task automatic ticks(input logic [7:0] c, input logic [31:0] e);
    apb(1'b1, CTRL_OFFSET, {24'h00_0000, c});
    repeat (3) @(posedge clk);
    n = 0;
    repeat (64) begin
      @(posedge clk);
      if (tick === 1'b1) n++;
    end
    chk("tick count", e, n);
  endtask

  task automatic complete_run;
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    #200000;
    err_total++;
    complete_run();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    sub_mode = 0; cm = 0; lvl = 0; err_total = 0; n_tests = 0;
    void'($urandom(97));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, MODE_OFFSET, 32'h0); chk("mode reset", 32'h0000_0048, rd);
    apb(1'b0, CTRL_OFFSET, 32'h0); chk("ctrl reset", 32'h0000_0000, rd);
    chk("pins reset", 32'h0000_0000, {run, clr_en, pin});
    // Mode register: corners then random
    for (int i = 0; i < 14; i++) begin
      logic [31:0] w;
      w = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0000_0000 : $urandom;
      apb(1'b1, MODE_OFFSET, w);
      apb(1'b0, MODE_OFFSET, 32'h0);
      chk("mode read", mode_exp(w), rd);
      chk("run", w[7], run);
      chk("buffer b", w[5], buf_b);
      chk("buffer a", w[4], buf_a);
      chk("pwm d", w[2], pwm_d);
      chk("pwm c", w[1], pwm_c);
      chk("pwm b", w[0], pwm_b);
    end
    // Unmapped address refused, leaves mode untouched
    apb(1'b1, MODE_OFFSET, 32'h0000_0080);
    apb(1'b1, 8'h08, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, err);
    apb(1'b0, 8'h08, 32'h0);
    chk("unmapped read", 32'h0000_0000, rd);
    chk("unmapped read error", 32'h0000_0001, err);
    chk("run kept", 32'h0000_0001, run);
    // clock select codes, random level bits alongside
    for (int c = 0; c < 8; c++) begin
      logic [3:0] lv;
      lv = 4'($urandom);
      ticks({1'b0, c[2:0], lv}, (c < 4) ? (64 >> c) : 16);
    end
    sub_mode <= 1'b1;
    ticks(8'h00, 8);
    ticks(8'h10, 32);
    sub_mode <= 1'b0;
    apb(1'b1, MODE_OFFSET, 32'h0000_0000);
    ticks(8'h40, 0);
    ticks(8'h00, 0);
    // clear on match A only when enabled
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, CTRL_OFFSET, {24'h00_0000, e[0], 7'h00});
      chk("clear enable", e[0], clr_en);
      cm <= 4'h1;
      // Sampled at the next edge, while the match pulse still stands
      @(posedge clk);
      chk("counter clear", e[0], clr);
      cm <= 4'h0;
      @(posedge clk);
      chk("clear idle", 32'h0000_0000, clr);
    end
    // initial levels, then channel takes over after match
    for (int i = 0; i < 6; i++) begin
      logic [3:0] l;
      l = (i == 0) ? 4'hF : 4'($urandom);
      lvl <= ~l;
      apb(1'b1, CTRL_OFFSET, {28'h000_0000, l});
      chk("pins init", l, pin);
      cm <= 4'h1 << (i % 4);
      @(posedge clk);
      cm <= 4'h0;
      repeat (2) @(posedge clk);
      chk("pins after match", l ^ (4'h1 << (i % 4)), pin);
    end
    // reset in mid-run clears every writable bit
    apb(1'b1, MODE_OFFSET, 32'h0000_00FF);
    apb(1'b1, CTRL_OFFSET, 32'h0000_00FF);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("mid reset outputs", 32'h0000_0000, {run, clr_en, buf_a, buf_b, pwm_b, pwm_c, pwm_d, pin});
    apb(1'b0, MODE_OFFSET, 32'h0); chk("mode mid reset", 32'h0000_0048, rd);
    apb(1'b0, CTRL_OFFSET, 32'h0); chk("ctrl mid reset", 32'h0000_0000, rd);
    complete_run();
  end
endmodule
`default_nettype wire
